/* File: psfd_pkg.sv */
package psfd_pkg;

	// ----------------------------------------------------------------
	// register map (word indices, byte address bits 11:2, one aligned word each)
	// ----------------------------------------------------------------
	localparam logic [9:0] PSFD_ADDR_BYPASS_CH4 = 10'h0A0;
	localparam logic [9:0] PSFD_ADDR_RAMP_CH4 = 10'h0A1;
	localparam logic [9:0] PSFD_IDX_BYPASS_CH4 = 10'h0A0;
	localparam logic [9:0] PSFD_IDX_RAMP_CH4 = 10'h0A1;
	localparam logic [9:0] PSFD_IDX_LOOP_STATUS = 10'h0B0;
	localparam logic [9:0] PSFD_IDX_IRQ_STATUS = 10'h0B1;
	localparam logic [9:0] PSFD_IDX_IRQ_MASK = 10'h0B2;
	localparam int PSFD_ADDR_W = 12;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int PSFD_BIT_HOLDOVER = 5;
	localparam int PSFD_BIT_REF_TWO_SEL = 4;
	localparam int PSFD_BIT_VCO_ABOVE = 3;
	localparam int PSFD_BIT_REF_TWO_ABOVE = 2;
	localparam int PSFD_BIT_REF_ONE_ABOVE = 1;
	localparam int PSFD_BIT_LOCKED = 0;
	localparam int PSFD_BIT_BYPASS = 0;
	localparam int PSFD_CAP_HI = 5;
	localparam int PSFD_CAP_LO = 3;
	localparam int PSFD_CUR_HI = 2;
	localparam int PSFD_CUR_LO = 0;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic PSFD_RST_BYPASS = 1'h1;
	localparam logic [2:0] PSFD_RST_CAP = 3'h0;
	localparam logic [2:0] PSFD_RST_CUR = 3'h0;
	localparam logic [5:0] PSFD_RST_MASK = 6'h00;
	localparam logic [5:0] PSFD_RST_IRQ = 6'h00;

	typedef struct packed {
		logic holdover_active;
		logic ref_two_selected;
		logic vco_above;
		logic ref_two_above;
		logic ref_one_above;
		logic locked;
	} psfd_status_s;

	typedef struct packed {
		logic bypass;
		logic [2:0] cap_code;
		logic [2:0] cur_code;
		logic [2:0] cap_count;
	} psfd_delay_cfg_s;

	typedef enum logic [1:0] {
		PSFD_IDLE,
		PSFD_ANSWER
	} psfd_bus_e;

endpackage : psfd_pkg

/* File: psfd_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module psfd_sync
	import psfd_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_srst,
	input wire logic [5:0] i_async,
	output logic [5:0] o_sync
);

	logic [5:0] meta_reg;

	// first stage feeds only the second
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			meta_reg <= 6'h00;
			o_sync <= 6'h00;
		end else begin
			meta_reg <= i_async;
			o_sync <= meta_reg;
		end
	end

endmodule : psfd_sync
`default_nettype wire

/* File: psfd_regs.sv */
// Behaviour
// - bit 5 shows holdover state, not enable
// - bit 4 shows second reference selected
// - bit 3 shows VCO above threshold
// - bit 2 shows second reference above threshold
// - bit 1 shows first reference above threshold
// - bit 0 shows digital lock detect
// - 0xA0 bit 0 bypasses delay, default one
// - 0xA1 bits 5:3 hold ramp capacitors
// - capacitor code decodes to count one-four
// - 0xA1 bits 2:0 hold ramp current
`timescale 1ns/1ps
`default_nettype none
module psfd_regs
	import psfd_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_srst,
	input wire logic [PSFD_ADDR_W-1:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	output logic [1:0] o_avs_response,
	input wire logic i_holdover_active,
	input wire logic i_ref_two_selected,
	input wire logic i_vco_above,
	input wire logic i_ref_two_above,
	input wire logic i_ref_one_above,
	input wire logic i_locked,
	output logic o_delay_bypass,
	output logic [2:0] o_ramp_cap_code,
	output logic [2:0] o_ramp_cur_code,
	output logic [2:0] o_ramp_cap_count,
	output logic o_irq
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [2:0] cap_count(input logic [2:0] code);
		// count = 4 minus number of ones in the code
		logic [2:0] n;
		n = 3'h4;
		case (code)
			3'h0: n = 3'h4;
			3'h1, 3'h2, 3'h4: n = 3'h3;
			3'h3, 3'h5, 3'h6: n = 3'h2;
			3'h7: n = 3'h1;
			default: n = 3'h4;
		endcase
		return n;
	endfunction : cap_count

	function automatic logic [9:0] word_index(input logic [PSFD_ADDR_W-1:0] a);
		return a[PSFD_ADDR_W-1:2];
	endfunction : word_index

	function automatic logic lane_hit(input logic strobe, input logic [3:0] be, input logic [9:0] at,
		input logic [9:0] want);
		// lane 0 carries every field of this map, a write without it is dropped
		return strobe && be[0] && (at == want);
	endfunction : lane_hit

	function automatic logic word_mapped(input logic [9:0] at);
		// the status word counts as mapped: a write to it is accepted and dropped
		logic hit;
		hit = 1'h0;
		case (at)
			PSFD_IDX_BYPASS_CH4: hit = 1'h1;
			PSFD_IDX_RAMP_CH4: hit = 1'h1;
			PSFD_IDX_LOOP_STATUS: hit = 1'h1;
			PSFD_IDX_IRQ_STATUS: hit = 1'h1;
			PSFD_IDX_IRQ_MASK: hit = 1'h1;
			default: hit = 1'h0;
		endcase
		return hit;
	endfunction : word_mapped

	// ----------------------------------------------------------------
	// monitor inputs come from analog clock domains
	// ----------------------------------------------------------------
	logic [5:0] mon_raw;
	logic [5:0] mon_sync;
	psfd_status_s live;

	assign mon_raw = {i_holdover_active, i_ref_two_selected, i_vco_above,
		i_ref_two_above, i_ref_one_above, i_locked};

	psfd_sync u_sync (
		.i_core_clk(i_core_clk),
		.i_srst(i_srst),
		.i_async(mon_raw),
		.o_sync(mon_sync)
	);

	assign live = psfd_status_s'(mon_sync);

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	psfd_bus_e state_reg;
	logic [9:0] idx;
	logic req;
	logic wr_bypass;
	logic wr_ramp;
	logic wr_irq_stat;
	logic wr_irq_mask;
	logic mapped;
	logic ans;
	logic wr_strobe;

	assign idx = word_index(i_avs_address);
	assign req = (i_avs_read | i_avs_write) && (state_reg == PSFD_IDLE);
	assign ans = (state_reg == PSFD_ANSWER);
	assign mapped = word_mapped(idx);

	// ----------------------------------------------------------------
	// write strobes
	// ----------------------------------------------------------------
	// a write lands at the edge where the master samples waitrequest low;
	// address and data are still held then, so nothing has to be captured
	assign wr_strobe = ans && i_avs_write;
	assign wr_bypass = lane_hit(wr_strobe, i_avs_byteenable, idx, PSFD_IDX_BYPASS_CH4);
	assign wr_ramp = lane_hit(wr_strobe, i_avs_byteenable, idx, PSFD_IDX_RAMP_CH4);
	assign wr_irq_stat = lane_hit(wr_strobe, i_avs_byteenable, idx, PSFD_IDX_IRQ_STATUS);
	assign wr_irq_mask = lane_hit(wr_strobe, i_avs_byteenable, idx, PSFD_IDX_IRQ_MASK);

	// ----------------------------------------------------------------
	// handshake
	// ----------------------------------------------------------------

	// one cycle of wait, then answer; waitrequest low in the answer cycle
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			state_reg <= PSFD_IDLE;
		end else begin
			case (state_reg)
				PSFD_IDLE: begin
					if (i_avs_read | i_avs_write) begin
						state_reg <= PSFD_ANSWER;
					end
				end
				PSFD_ANSWER: state_reg <= PSFD_IDLE;
				default: state_reg <= PSFD_IDLE;
			endcase
		end
	end

	// reset holds waitrequest high so no transfer can complete during it
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			o_avs_waitrequest <= 1'b1;
		end else begin
			o_avs_waitrequest <= ~req;
		end
	end

	// ----------------------------------------------------------------
	// fine delay configuration
	// ----------------------------------------------------------------
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			o_delay_bypass <= PSFD_RST_BYPASS;
		end else if (wr_bypass) begin
			o_delay_bypass <= i_avs_writedata[PSFD_BIT_BYPASS];
		end
	end

	// ----------------------------------------------------------------
	// ramp fields
	// ----------------------------------------------------------------
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			o_ramp_cap_code <= PSFD_RST_CAP;
		end else if (wr_ramp) begin
			o_ramp_cap_code <= i_avs_writedata[PSFD_CAP_HI:PSFD_CAP_LO];
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			o_ramp_cur_code <= PSFD_RST_CUR;
		end else if (wr_ramp) begin
			o_ramp_cur_code <= i_avs_writedata[PSFD_CUR_HI:PSFD_CUR_LO];
		end
	end

	// ----------------------------------------------------------------
	// capacitor count
	// ----------------------------------------------------------------
	// decoded from the write data, not from the stored code, so the
	// count never lags the code by a cycle
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			o_ramp_cap_count <= cap_count(PSFD_RST_CAP);
		end else if (wr_ramp) begin
			o_ramp_cap_count <= cap_count(i_avs_writedata[PSFD_CAP_HI:PSFD_CAP_LO]);
		end
	end

	// ----------------------------------------------------------------
	// interrupts: any change of a monitored status bit is an event
	// ----------------------------------------------------------------
	logic [5:0] prev_reg;
	logic [5:0] irq_stat_reg;
	logic [5:0] irq_mask_reg;
	logic [5:0] irq_event;

	// ----------------------------------------------------------------
	// change detect
	// ----------------------------------------------------------------
	assign irq_event = mon_sync ^ prev_reg;

	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			prev_reg <= 6'h00;
		end else begin
			prev_reg <= mon_sync;
		end
	end

	// ----------------------------------------------------------------
	// interrupt status
	// ----------------------------------------------------------------
	// set wins over a write-one clear in the same cycle
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			irq_stat_reg <= PSFD_RST_IRQ;
		end else if (wr_irq_stat) begin
			irq_stat_reg <= (irq_stat_reg & ~i_avs_writedata[5:0]) | irq_event;
		end else begin
			irq_stat_reg <= irq_stat_reg | irq_event;
		end
	end

	// ----------------------------------------------------------------
	// interrupt mask
	// ----------------------------------------------------------------
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			irq_mask_reg <= PSFD_RST_MASK;
		end else if (wr_irq_mask) begin
			irq_mask_reg <= i_avs_writedata[5:0];
		end
	end

	// ----------------------------------------------------------------
	// next interrupt state
	// ----------------------------------------------------------------
	logic [5:0] irq_stat_next;
	logic [5:0] irq_mask_next;

	always_comb begin
		irq_stat_next = irq_stat_reg | irq_event;
		if (wr_irq_stat) begin
			irq_stat_next = (irq_stat_reg & ~i_avs_writedata[5:0]) | irq_event;
		end
		irq_mask_next = wr_irq_mask ? i_avs_writedata[5:0] : irq_mask_reg;
	end

	// ----------------------------------------------------------------
	// interrupt output
	// ----------------------------------------------------------------
	// registered so the output follows the stored state in the same cycle
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= |(irq_stat_next & irq_mask_next);
		end
	end

	// ----------------------------------------------------------------
	// read data; status is live and reading clears nothing
	// ----------------------------------------------------------------
	logic [7:0] status_byte;
	psfd_delay_cfg_s cfg;

	// one view of the delay settings for the read mux
	assign cfg = {o_delay_bypass, o_ramp_cap_code, o_ramp_cur_code, o_ramp_cap_count};

	// ----------------------------------------------------------------
	// status word
	// ----------------------------------------------------------------
	// the two bits above the six monitors read as zero
	always_comb begin
		status_byte = 8'h00;
		status_byte[PSFD_BIT_HOLDOVER] = live.holdover_active;
		status_byte[PSFD_BIT_REF_TWO_SEL] = live.ref_two_selected;
		status_byte[PSFD_BIT_VCO_ABOVE] = live.vco_above;
		status_byte[PSFD_BIT_REF_TWO_ABOVE] = live.ref_two_above;
		status_byte[PSFD_BIT_REF_ONE_ABOVE] = live.ref_one_above;
		status_byte[PSFD_BIT_LOCKED] = live.locked;
	end

	logic [31:0] rdata;

	always_comb begin
		rdata = 32'h0000_0000;
		case (idx)
			PSFD_IDX_BYPASS_CH4: rdata[PSFD_BIT_BYPASS] = cfg.bypass;
			PSFD_IDX_RAMP_CH4: begin
				rdata[PSFD_CAP_HI:PSFD_CAP_LO] = cfg.cap_code;
				rdata[PSFD_CUR_HI:PSFD_CUR_LO] = cfg.cur_code;
			end
			PSFD_IDX_LOOP_STATUS: rdata[7:0] = status_byte;
			PSFD_IDX_IRQ_STATUS: rdata[5:0] = irq_stat_reg;
			PSFD_IDX_IRQ_MASK: rdata[5:0] = irq_mask_reg;
			default: rdata = 32'h0000_0000;
		endcase
	end

	// ----------------------------------------------------------------
	// bus answer
	// ----------------------------------------------------------------
	// writes to the status word decode to no register at all
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			o_avs_readdata <= 32'h0000_0000;
		end else if (req) begin
			o_avs_readdata <= i_avs_read ? rdata : 32'h0000_0000;
		end
	end

	// ----------------------------------------------------------------
	// response code
	// ----------------------------------------------------------------
	// only unmapped words answer with an error, so software may write
	// the whole map blindly without tripping on the status word
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			o_avs_response <= 2'h0;
		end else if (req) begin
			o_avs_response <= mapped ? 2'h0 : 2'h2;
		end
	end

endmodule : psfd_regs
`default_nettype wire

/* File: psfd_regs_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module psfd_regs_assertions
	import psfd_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_srst,
	input wire logic [PSFD_ADDR_W-1:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	input wire logic [31:0] o_avs_readdata,
	input wire logic o_avs_waitrequest,
	input wire logic [1:0] o_avs_response,
	input wire logic o_delay_bypass,
	input wire logic [2:0] o_ramp_cap_code,
	input wire logic [2:0] o_ramp_cur_code,
	input wire logic [2:0] o_ramp_cap_count
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_srst);
	// ----------------------------------------------------------------
	// bus answer and register updates
	// ----------------------------------------------------------------
	wire req = i_avs_read | i_avs_write;
	wire wb = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0];
	ans_req_a: assert property (req && o_avs_waitrequest |=> !o_avs_waitrequest) else $error("no answer");
	ack_one_a: assert property (!o_avs_waitrequest |=> o_avs_waitrequest) else $error("answer too long");
	ack_cause_a: assert property (!o_avs_waitrequest |-> $past(req)) else $error("answer without request");
	resp_code_a: assert property (!o_avs_waitrequest |-> o_avs_response inside {2'h0, 2'h2}) else $error("bad response");
	upper_zero_a: assert property (!o_avs_waitrequest |-> o_avs_readdata[31:8] == 24'h0) else $error("upper bits set");
	bypass_wr_a: assert property (wb && i_avs_address == 12'h280 |=> o_delay_bypass == $past(i_avs_writedata[0]))
		else $error("bypass not stored");
	ramp_wr_a: assert property (wb && i_avs_address == 12'h284 |=>
		{o_ramp_cap_code, o_ramp_cur_code} == $past(i_avs_writedata[5:0])) else $error("ramp not stored");
	ramp_hold_a: assert property (!(i_avs_write && i_avs_address == 12'h284) |=>
		$stable({o_ramp_cap_code, o_ramp_cur_code})) else $error("ramp changed");
	cap_decode_a: assert property ($stable(o_ramp_cap_code) |->
		o_ramp_cap_count == 3'(4 - $countones(o_ramp_cap_code))) else $error("bad count");
endmodule : psfd_regs_assertions
`default_nettype wire

/* File: psfd_regs_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin bad_count++; \
	$display("[ERR] %s exp %0h got %0h", n, e, s); end end
module psfd_regs_tb;
	import psfd_pkg::*;
	logic clk = 0, srst = 1, rd = 0, wr = 0, irq, wreq, bp;
	logic [11:0] adr = 0;
	logic [31:0] wd = 0, rdat;
	logic [1:0] resp;
	logic [5:0] mon = 0;
	logic [2:0] cap, cur, cnt;
	logic [33:0] exq[$];
	logic [33:0] exp_v;
	int bad_count = 0, n_tests = 0, cyc = 0, seed = 97;
	initial forever #25 clk = ~clk;
	psfd_regs DUT (.i_core_clk(clk), .i_srst(srst), .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
		.i_avs_writedata(wd), .i_avs_byteenable(4'hF), .o_avs_readdata(rdat), .o_avs_waitrequest(wreq),
		.o_avs_response(resp), .i_holdover_active(mon[5]), .i_ref_two_selected(mon[4]), .i_vco_above(mon[3]),
		.i_ref_two_above(mon[2]), .i_ref_one_above(mon[1]), .i_locked(mon[0]), .o_delay_bypass(bp),
		.o_ramp_cap_code(cap), .o_ramp_cur_code(cur), .o_ramp_cap_count(cnt), .o_irq(irq));
	task conclude;
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : conclude
	// ----------------------------------------------------------------
	// one bus access; reads leave their expectation for the monitor
	// ----------------------------------------------------------------
	task acc(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [33:0] e);
		@(posedge clk);
		rd <= !w;
		wr <= w;
		adr <= a;
		wd <= d;
		if (!w) exq.push_back(e);
		do @(posedge clk); while (wreq !== 1'b0);
		rd <= 0;
		wr <= 0;
	endtask : acc
	always @(posedge clk) begin
		cyc++;
		if (cyc > 4000) begin
			bad_count++;
			conclude();
		end
		if (wreq === 1'b0 && rd) begin
			exp_v = exq.pop_front();
			`CHK("readback", exp_v, {resp, rdat})
		end
	end
	initial begin
		logic [2:0] c;
		repeat (6) @(posedge clk);
		srst <= 0;
		@(posedge clk);
		`CHK("reset", 10'h204, {bp, cap, cur, cnt})
		acc(0, 12'h280, 0, 34'h1);
		acc(0, 12'h284, 0, 34'h0);
		for (int i = 0; i < 8; i++) begin
			c = 3'($random(seed));
			acc(1, 12'h284, {26'h0, 3'(i), c}, 0);
			acc(0, 12'h284, 0, {28'h0, 3'(i), c});
			`CHK("cap count", 3'(4 - $countones(3'(i))), cnt)
		end
		acc(1, 12'h280, 32'h0, 0);
		@(posedge clk);
		`CHK("bypass", 1'b0, bp)
		acc(1, 12'h280, 32'h1, 0);
		@(posedge clk);
		`CHK("bypass", 1'b1, bp)
		for (int i = 0; i < 7; i++) begin
			@(posedge clk) mon <= (i < 6) ? 6'(1 << i) : 6'($random(seed));
			repeat (3) @(posedge clk);
			acc(0, 12'h2C0, 0, {28'h0, mon});
		end
		acc(1, 12'h2C0, 32'hFF, 0);
		acc(0, 12'h2C0, 0, {28'h0, mon});
		acc(0, 12'h3FC, 0, {2'h2, 32'h0});
		acc(1, 12'h2C8, 32'h1, 0);
		acc(1, 12'h2C4, 32'h3F, 0);
		@(posedge clk);
		`CHK("irq clear", 1'b0, irq)
		@(posedge clk) mon[0] <= ~mon[0];
		repeat (4) @(posedge clk);
		`CHK("irq set", 1'b1, irq)
		acc(1, 12'h2C8, 32'h0, 0);
		repeat (2) @(posedge clk);
		`CHK("irq masked", 1'b0, irq)
		conclude();
	end
endmodule : psfd_regs_tb
bind psfd_regs psfd_regs_assertions chk (.i_core_clk(i_core_clk), .i_srst(i_srst), .i_avs_address(i_avs_address),
	.i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
	.i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
	.o_avs_response(o_avs_response), .o_delay_bypass(o_delay_bypass), .o_ramp_cap_code(o_ramp_cap_code),
	.o_ramp_cur_code(o_ramp_cur_code), .o_ramp_cap_count(o_ramp_cap_count));
`default_nettype wire
